// File: hdl/fpt_cfg.svh
// Register map, control fields, reset values and sizes of the transfer control block
`ifndef FPT_CFG_SVH
`define FPT_CFG_SVH

// Register byte offsets
`define FPT_OFF_CONTROL 8'h00
`define FPT_OFF_STATUS 8'h04
`define FPT_OFF_DATA 8'h08

// Control byte fields
`define FPT_CTL_POLL_OFF 7
`define FPT_CTL_DIR 6
`define FPT_CTL_CLEAR 4
`define FPT_CTL_FP_OFF 3
`define FPT_CTL_LINES_MSB 2

// Control reset: polls off, output, data path held clear, frontplane off
`define FPT_CTL_RESET 8'h98

// Status word fields
`define FPT_ST_DATA 0
`define FPT_ST_STROBE_N 1
`define FPT_ST_POLL 2
`define FPT_ST_DIR_FAULT 3
`define FPT_ST_STS_LSB 4
`define FPT_ST_PERIPHERAL_ATTENTION 7
`define FPT_ST_OCC_LSB 8

// FIFO memory depth in words, and the word transfer size code
`define FPT_DEPTH 7'h40
`define FPT_HSIZE_WORD 3'h2

`endif

// File: hdl/fpt_pkg.sv
// Types shared by the transfer control block
package fpt_pkg;

  // Register selected by a bus access
  typedef enum logic [1:0] {FPT_SEL_CTRL, FPT_SEL_STAT, FPT_SEL_DATA, FPT_SEL_NONE} fpt_sel_t;

  // Frontplane handshake states
  typedef enum logic [1:0] {FPT_FP_IDLE, FPT_FP_STROBE, FPT_FP_RELEASE} fpt_fp_state_t;

endpackage

// File: hdl/fpt_mem_if.sv
// Signals between the data path control and its FIFO memory
`timescale 1ns/1ps
interface fpt_mem_if;
  logic wr_en;
  logic [5:0] wr_addr;
  logic [15:0] wr_data;
  logic rd_en;
  logic [5:0] rd_addr;
  logic [15:0] rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr, output rd_data);
endinterface

// File: hdl/fpt_mem.sv
// Sixty-four word FIFO storage with registered read data
`timescale 1ns/1ps
module fpt_mem
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Storage port
  fpt_mem_if.mem mp
);

  logic [15:0] store [0:63];

  // Array write, no reset needed on storage
  always_ff @(posedge hclk)
  begin
    if (mp.wr_en)
    begin
      store[mp.wr_addr] <= mp.wr_data;
    end
  end

  // Read word lands one cycle after the request
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mp.rd_data <= 16'h0000;
    end
    else if (mp.rd_en)
    begin
      mp.rd_data <= store[mp.rd_addr];
    end
  end

endmodule

// File: hdl/fpt_top.sv
// FIFO-buffered 16-bit parallel transfer control with AHB-Lite register access
`timescale 1ns/1ps
`include "fpt_cfg.svh"

module fpt_top
  import fpt_pkg::*;
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Backplane poll answer
  output logic service_request_poll,
  // Frontplane data lines
  output logic [15:0] periph_data_out,
  output logic periph_data_oe,
  input wire logic [15:0] periph_data_in,
  // Frontplane handshake and control
  output logic data_available_strobe,
  input wire logic peripheral_ack_flag,
  output logic direction_line,
  output logic [2:0] peripheral_control_outputs,
  input wire logic [2:0] peripheral_status_lines,
  input wire logic peripheral_attention
);

  // Pointer step with wrap over the storage
  function automatic logic [5:0] ptr_inc(input logic [5:0] p);
    ptr_inc = p + 6'h01;
  endfunction

  // Map a byte offset to a register
  function automatic fpt_sel_t addr_decode(input logic [7:0] a);
    if (a == `FPT_OFF_CONTROL)
      addr_decode = FPT_SEL_CTRL;
    else if (a == `FPT_OFF_STATUS)
      addr_decode = FPT_SEL_STAT;
    else if (a == `FPT_OFF_DATA)
      addr_decode = FPT_SEL_DATA;
    else
      addr_decode = FPT_SEL_NONE;
  endfunction

  fpt_mem_if mif ();

  logic [7:0] ctrl_reg;
  logic dp_valid_reg;
  logic dp_write_reg;
  fpt_sel_t dp_sel_reg;
  logic [6:0] cnt_reg;
  logic [6:0] cnt_next;
  logic [5:0] wptr_reg;
  logic [5:0] rptr_reg;
  logic rd_pend_reg;
  logic [15:0] s1_reg;
  logic s1_v_reg;
  logic [15:0] s2_reg;
  logic s2_v_reg;
  logic dir_fault_reg;
  logic dir_fault_next;
  fpt_fp_state_t fp_reg;
  fpt_fp_state_t fp_next;

  // Bus address phase and data phase strobes
  wire addr_phase = hsel & hready & htrans[1] & (hsize == `FPT_HSIZE_WORD);
  wire ctl_wr = dp_valid_reg & dp_write_reg & (dp_sel_reg == FPT_SEL_CTRL);
  wire data_wr = dp_valid_reg & dp_write_reg & (dp_sel_reg == FPT_SEL_DATA);
  wire data_rd = dp_valid_reg & ~dp_write_reg & (dp_sel_reg == FPT_SEL_DATA);
  wire [7:0] ctl_new = hwdata[7:0];

  wire poll_en = ~ctrl_reg[`FPT_CTL_POLL_OFF];
  wire dir_in = ctrl_reg[`FPT_CTL_DIR];
  wire clear = ctrl_reg[`FPT_CTL_CLEAR];
  wire fp_en = ~ctrl_reg[`FPT_CTL_FP_OFF];

  // FIFO bound, two stages follow it
  wire mem_full = (cnt_reg == `FPT_DEPTH);
  wire mem_has = (cnt_reg != 7'h00);
  wire fp_take = (fp_reg == FPT_FP_STROBE) & peripheral_ack_flag;

  // Word sources and sinks chosen by direction
  wire push_bus = data_wr & ~dir_in & ~mem_full & ~clear;
  wire push_fp = fp_take & dir_in & ~clear;
  wire push = push_bus | push_fp;
  wire [15:0] push_data = dir_in ? periph_data_in : hwdata[15:0];
  wire pop_s2 = ~clear & s2_v_reg & (dir_in ? data_rd : fp_take);
  wire s2_load = ~clear & s1_v_reg & (~s2_v_reg | pop_s2);
  wire rd_issue = ~clear & mem_has & ~rd_pend_reg & (~s1_v_reg | s2_load);

  // Storage connections
  assign mif.wr_en = push;
  assign mif.wr_addr = wptr_reg;
  assign mif.wr_data = push_data;
  assign mif.rd_en = rd_issue;
  assign mif.rd_addr = rptr_reg;

  fpt_mem u_mem (
    .hclk(hclk),
    .hresetn(hresetn),
    .mp(mif.mem)
  );

  // Occupancy over FIFO, fetch in flight and both stages
  wire [6:0] occupancy = cnt_reg + {6'h00, rd_pend_reg} + {6'h00, s1_v_reg} + {6'h00, s2_v_reg};
  wire data_present = (occupancy != 7'h00);

  // direction flip with clear released on both sides
  wire dir_flip_bad = ctl_wr & (ctl_new[`FPT_CTL_DIR] != dir_in) & ~clear & ~ctl_new[`FPT_CTL_CLEAR];
  // Fault flag, set wins over clear
  assign dir_fault_next = dir_flip_bad | (dir_fault_reg & ~(ctl_wr & ctl_new[`FPT_CTL_CLEAR]));

  // output answers polls while room exists
  // input answers polls only with a word at the exit
  // words left after frontplane stop keep the poll answer up
  assign service_request_poll = poll_en & ~clear & (dir_in ? s2_v_reg : ~mem_full);

  // status word with low-true strobe bit
  wire [31:0] status_word = {17'h00000, occupancy, peripheral_attention, peripheral_status_lines,
                             dir_fault_reg, service_request_poll, ~data_available_strobe, data_present};

  // Read data for the current data phase
  assign hrdata = ~dp_valid_reg | dp_write_reg ? 32'h00000000 :
                  dp_sel_reg == FPT_SEL_CTRL ? {24'h000000, ctrl_reg} :
                  dp_sel_reg == FPT_SEL_STAT ? status_word :
                  dp_sel_reg == FPT_SEL_DATA ? {16'h0000, s2_v_reg ? s2_reg : 16'h0000} : 32'h00000000;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // control lines straight from control bits
  assign peripheral_control_outputs = ctrl_reg[`FPT_CTL_LINES_MSB:0];
  assign direction_line = dir_in;
  assign periph_data_out = s2_reg;
  assign periph_data_oe = ~dir_in;
  // strobe only rises in the strobe state
  assign data_available_strobe = (fp_reg == FPT_FP_STROBE);

  // FIFO count bookkeeping
  assign cnt_next = cnt_reg + {6'h00, push} - {6'h00, rd_issue};

  // Frontplane handshake sequencing
  always_comb
  begin
    fp_next = fp_reg;
    unique case (fp_reg)
      FPT_FP_IDLE:
      begin
        // output strobes once a word sits on the lines
        // input requests only with frontplane enabled
        // input asks whenever storage has room
        if (fp_en & ~clear & ~peripheral_ack_flag & (dir_in ? ~mem_full : s2_v_reg))
          fp_next = FPT_FP_STROBE;
      end
      FPT_FP_STROBE:
      begin
        if (peripheral_ack_flag)
          fp_next = FPT_FP_RELEASE;
      end
      FPT_FP_RELEASE:
      begin
        // flag must fall before the next word
        if (~peripheral_ack_flag)
          fp_next = FPT_FP_IDLE;
      end
    endcase
    // disabling the frontplane halts any handshake
    if (~fp_en | clear)
      fp_next = FPT_FP_IDLE;
  end

  // Bus data phase capture and control register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_sel_reg <= FPT_SEL_NONE;
      ctrl_reg <= `FPT_CTL_RESET;
      dir_fault_reg <= 1'b0;
    end
    else
    begin
      if (hready)
      begin
        dp_valid_reg <= addr_phase;
        dp_write_reg <= hwrite;
        dp_sel_reg <= addr_decode(haddr[7:0]);
      end
      if (ctl_wr)
        ctrl_reg <= ctl_new;
      dir_fault_reg <= dir_fault_next;
    end
  end

  // Handshake state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fp_reg <= FPT_FP_IDLE;
    else
      fp_reg <= fp_next;
  end

  // FIFO pointers and count
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_reg <= 7'h00;
      wptr_reg <= 6'h00;
      rptr_reg <= 6'h00;
      rd_pend_reg <= 1'b0;
    end
    else if (clear)
    begin
      cnt_reg <= 7'h00;
      wptr_reg <= 6'h00;
      rptr_reg <= 6'h00;
      rd_pend_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      rd_pend_reg <= rd_issue;
      if (push)
        wptr_reg <= ptr_inc(wptr_reg);
      if (rd_issue)
        rptr_reg <= ptr_inc(rptr_reg);
    end
  end

  // First pipeline stage after the FIFO
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s1_reg <= 16'h0000;
      s1_v_reg <= 1'b0;
    end
    else if (clear)
      s1_v_reg <= 1'b0;
    else if (rd_pend_reg)
    begin
      s1_reg <= mif.rd_data;
      s1_v_reg <= 1'b1;
    end
    else if (s2_load)
      s1_v_reg <= 1'b0;
  end

  // Exit stage, drives the data lines or the bus read
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s2_reg <= 16'h0000;
      s2_v_reg <= 1'b0;
    end
    else if (clear)
      s2_v_reg <= 1'b0;
    else if (s2_load)
    begin
      s2_reg <= s1_reg;
      s2_v_reg <= 1'b1;
    end
    else if (pop_s2)
      s2_v_reg <= 1'b0;
  end

endmodule

// File: testbench/fpt_top_chk.sv
// Port checker for the transfer control block
`timescale 1ns/1ps
module fpt_top_chk
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // Frontplane
  input wire logic service_request_poll,
  input wire logic [15:0] periph_data_out,
  input wire logic periph_data_oe,
  input wire logic data_available_strobe,
  input wire logic peripheral_ack_flag,
  input wire logic direction_line,
  input wire logic [2:0] peripheral_control_outputs
);
  logic ap;
  logic dp;
  // Control write in address phase
  assign ap = hsel & hready & htrans[1] & hwrite & (hsize == 3'h2) & (haddr[7:0] == 8'h00);
  // Control write in data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dp <= 1'b0;
    else
      dp <= ap;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_ctl;
    dp |=> peripheral_control_outputs == $past(hwdata[2:0]) && direction_line == $past(hwdata[6]);
  endproperty
  a_ctl: assert property (p_ctl) else $error("control lines wrong");
  property p_hold;
    $changed(peripheral_control_outputs) || $changed(direction_line) |-> $past(dp);
  endproperty
  a_hold: assert property (p_hold) else $error("control lines moved");
  property p_oe;
    periph_data_oe == !direction_line;
  endproperty
  a_oe: assert property (p_oe) else $error("enable wrong");
  property p_rise;
    $rose(data_available_strobe) |-> !$past(peripheral_ack_flag);
  endproperty
  a_rise: assert property (p_rise) else $error("strobe over flag");
  property p_fall;
    $fell(data_available_strobe) |-> $past(peripheral_ack_flag) || $past(dp) || $past(dp, 2);
  endproperty
  a_fall: assert property (p_fall) else $error("strobe dropped early");
  property p_data;
    data_available_strobe && $past(data_available_strobe) && !direction_line |-> $stable(periph_data_out);
  endproperty
  a_data: assert property (p_data) else $error("data moved");
  property p_stop;
    dp && (hwdata[3] || hwdata[4]) |-> ##2 !data_available_strobe;
  endproperty
  a_stop: assert property (p_stop) else $error("strobe not stopped");
  property p_poll;
    dp && (hwdata[7] || hwdata[4]) |=> !service_request_poll;
  endproperty
  a_poll: assert property (p_poll) else $error("poll not off");
endmodule
bind fpt_top fpt_top_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .service_request_poll(service_request_poll),
  .periph_data_out(periph_data_out), .periph_data_oe(periph_data_oe), .data_available_strobe(data_available_strobe),
  .peripheral_ack_flag(peripheral_ack_flag), .direction_line(direction_line),
  .peripheral_control_outputs(peripheral_control_outputs));

// File: testbench/fpt_periph.sv
// Peripheral model with strobe and flag handshake
`timescale 1ns/1ps
module fpt_periph
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // From the device, and the flag delay set by the testbench
  input wire logic stb,
  input wire logic dir,
  input wire logic [15:0] dout,
  input wire logic [1:0] lag,
  // To the device
  output logic flag,
  output logic [15:0] din
);
  logic [15:0] got[$];
  logic [15:0] seq;
  logic [1:0] w;
  // Released lines show the inverse
  assign din = flag ? seq : ~seq;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flag <= 1'b0;
      seq <= 16'hA000;
      w <= 2'h0;
    end
    else if (stb && !flag)
    begin
      w <= w + 2'h1;
      if (w >= lag)
      begin
        flag <= 1'b1;
        w <= 2'h0;
        if (!dir)
          got.push_back(dout);
      end
    end
    else if (!stb && flag)
    begin
      flag <= 1'b0;
      if (dir)
        seq <= seq + 16'h1;
    end
  end
endmodule

// File: testbench/tb_top.sv
// Testbench for the transfer control block
`timescale 1ns/1ps
`include "fpt_cfg.svh"
module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = `FPT_HSIZE_WORD;
  logic [1:0] lag = 2'h0;
  logic hreadyout, hresp, poll, oe, stb, flag, dline;
  logic [31:0] hrdata, r;
  logic [15:0] dout, din;
  logic [2:0] pco;
  int err_total = 0;
  int num_checks = 0;
  always #25 hclk = ~hclk;
  fpt_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .service_request_poll(poll), .periph_data_out(dout),
    .periph_data_oe(oe), .periph_data_in(din), .data_available_strobe(stb), .peripheral_ack_flag(flag),
    .direction_line(dline), .peripheral_control_outputs(pco), .peripheral_status_lines(3'h5),
    .peripheral_attention(1'b0));
  fpt_periph u_per (.clk(hclk), .rst_n(hresetn), .stb(stb), .dir(dline), .dout(dout), .lag(lag),
    .flag(flag), .din(din));
  task chk(input logic [31:0] s, input logic [31:0] e, input string n);
    num_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task cw(input logic [31:0] d);
    bus(1'b1, `FPT_OFF_CONTROL, d);
    @(posedge hclk);
  endtask
  task st;
    bus(1'b0, `FPT_OFF_STATUS, 32'h0);
  endtask
  task wt(input logic [31:0] m, input logic [31:0] v, input string n);
    int i;
    for (i = 0; i < 300; i++)
    begin
      st;
      if ((r & m) === v)
        break;
    end
    chk(r & m, v, n);
  endtask
  task t_reset;
    bus(1'b0, `FPT_OFF_CONTROL, 32'h0);
    chk(r, 32'h98, "control");
    chk({31'h0, hresp}, 32'h0, "response");
    st;
    chk(r, 32'h52, "status");
    bus(1'b1, 8'h0C, 32'hFF);
    bus(1'b0, 8'h0C, 32'h0);
    chk(r, 32'h0, "unmapped");
    // Byte sized write must be ignored
    hsize <= 3'h0;
    bus(1'b1, `FPT_OFF_CONTROL, 32'h8D);
    hsize <= `FPT_HSIZE_WORD;
    bus(1'b0, `FPT_OFF_CONTROL, 32'h0);
    chk(r, 32'h98, "byte write");
    $display("reset test done");
  endtask
  task t_out;
    int i;
    lag <= 2'h2;
    cw(32'h8D);
    chk({29'h0, pco}, 32'h5, "lines");
    cw(32'h0D);
    chk({31'h0, poll}, 32'h1, "poll empty");
    cw(32'h05);
    repeat (8) @(posedge hclk);
    chk({31'h0, stb}, 32'h0, "strobe idle");
    for (i = 1; i < 4; i++)
      bus(1'b1, `FPT_OFF_DATA, 32'h1111 * i);
    wt(32'h3, 32'h2, "output done");
    chk(32'(u_per.got.size()), 32'h3, "taken");
    for (i = 0; i < 3; i++)
      chk({16'h0, u_per.got[i]}, 32'h1111 * (i + 1), "word out");
    $display("output test done");
  endtask
  task t_cap;
    int i;
    cw(32'h9D);
    cw(32'h8D);
    for (i = 0; i < 67; i++)
      bus(1'b1, `FPT_OFF_DATA, i);
    st;
    chk(r & 32'h7F01, 32'h4201, "full");
    cw(32'h9D);
    st;
    chk(r & 32'h7F01, 32'h0, "cleared");
    $display("capacity test done");
  endtask
  task t_in;
    int i;
    lag <= 2'h0;
    cw(32'hDD);
    chk({31'h0, dline}, 32'h1, "direction");
    chk({31'h0, oe}, 32'h0, "enable");
    cw(32'hCD);
    cw(32'h4D);
    repeat (8) @(posedge hclk);
    chk({31'h0, poll}, 32'h0, "poll no data");
    cw(32'h45);
    wt(32'h7F00, 32'h4200, "fill");
    chk({31'h0, poll}, 32'h1, "poll data");
    cw(32'h4D);
    for (i = 0; i < 3; i++)
    begin
      bus(1'b0, `FPT_OFF_DATA, 32'h0);
      chk(r, 32'hA000 + i, "word in");
    end
    chk({31'h0, poll}, 32'h1, "surplus");
    st;
    chk(r & 32'h8, 32'h0, "no fault");
    cw(32'h0D);
    st;
    chk(r & 32'h8, 32'h8, "fault");
    cw(32'h1D);
    st;
    chk(r & 32'h8, 32'h0, "fault gone");
    $display("input test done");
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_out;
    t_cap;
    t_in;
    end_of_test;
  end
  // Watchdog
  initial
  begin
    #1000000;
    err_total++;
    end_of_test;
  end
endmodule
